// ===== hdl/usc_cfg.svh
// Offsets, field positions, reset values and sizes of the serial block.
// Assumes byte addresses on a 32-bit Avalon-MM port, one word per register.
`ifndef USC_CFG_SVH
`define USC_CFG_SVH

`define USC_AW            12
`define USC_OFF_DATA      12'h000
`define USC_OFF_RSR       12'h004
`define USC_OFF_FLAG      12'h018
`define USC_OFF_ILPR      12'h020
`define USC_OFF_IBRD      12'h024
`define USC_OFF_FBRD      12'h028
`define USC_OFF_LCRH      12'h02C
`define USC_OFF_CTL       12'h030

`define USC_LC_BRK        0
`define USC_LC_PEN        1
`define USC_LC_EPS        2
`define USC_LC_STP2       3
`define USC_LC_WLEN_LO    5
`define USC_LC_SPS        7

`define USC_CT_EN         0
`define USC_CT_SIR        1
`define USC_CT_SIRLP      2
`define USC_CT_TXE        8
`define USC_CT_RXE        9
`define USC_CTL_RST       10'h300

`define USC_FL_BUSY       3
`define USC_FL_RXFE       4
`define USC_FL_TXFF       5
`define USC_FL_RXFF       6
`define USC_FL_TXFE       7

`define USC_DEPTH         5'h10
`define USC_SUB_LAST      4'hF
`define USC_START_MID     4'h7
`define USC_IR_PULSE      4'h3
`define USC_LP_PULSE      2'h3

`endif

// ===== hdl/usc_pkg.sv
// Types shared by the serial block and its bench.
// Assumes usc_cfg.svh for all numeric constants.
package usc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_START = 3'h1,
        ST_DATA  = 3'h2,
        ST_PAR   = 3'h3,
        ST_STOP  = 3'h4
    } usc_fsm_t;

    typedef struct packed {
        logic [11:0] address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } usc_avs_req_t;

    typedef struct packed {
        logic               ack;
        logic [15:0]        rdata;
        logic [15:0]        ibrd;
        logic [5:0]         fbrd;
        logic [7:0]         lcrh;
        logic [29:0]        cfg;
        logic [9:0]         ctl;
        logic [7:0]         ilpr;
        logic [15:0]        bcnt;
        logic [5:0]         facc;
        logic [7:0]         lcnt;
        logic [15:0][7:0]   txm;
        logic [3:0]         txr;
        logic [4:0]         txc;
        logic [15:0][11:0]  rxm;
        logic [3:0]         rxr;
        logic [4:0]         rxc;
        usc_fsm_t           tst;
        logic [3:0]         tsub;
        logic [2:0]         tbit;
        logic [7:0]         tsh;
        logic               tpar;
        logic [1:0]         tlp;
        logic               txd;
        usc_fsm_t           rst;
        logic [3:0]         rsub;
        logic [2:0]         rbit;
        logic [7:0]         rsh;
        logic               rpe;
        logic               rpb;
        logic               rprev;
        logic [2:0]         sync;
        logic               rline;
        logic [3:0]         irh;
        logic               oepend;
        logic [3:0]         rsr;
    } usc_state_t;
endpackage

// ===== hdl/usc_top.sv
// Serial transmitter/receiver with fractional baud generator, FIFOs and IR codec.
// Assumes an Avalon-MM master on mclk and an asynchronous serial_rx_pin.
// Function
// - Start, data LSB first, parity, stop bits
// - Five to eight data bits, one/two stops
// - Even, odd, stick or no parity
// - Divisor: 16-bit integer, 6-bit fraction
// - Oversample tick at sixteen times baud
// - Divisor and line settings latch on line write
// - Per-direction enables, both set after reset
// - Disable finishes current character first
// - Sixteen-entry FIFOs, four status bits per receive
// - FIFO write starts frames, back to back
// - Busy until FIFO empty and shifter done
// - Start rejected if high at eighth tick
// - Data sampled every sixteenth tick, then parity
// - Low stop flags framing error, then store
// - Overrun, parity, framing, break stored with data
// - Break generated on transmit, detected on receive
// - IR zero is 3/16 high pulse
// - IR low pulse decodes to zero
// - Low-power pulse three divided-clock periods
//
// Chosen here: the address map and the Avalon-MM slave port.
`include "usc_cfg.svh"

module usc_top (
    input  wire logic                  mclk,
    input  wire logic                  rstn,
    input  wire usc_pkg::usc_avs_req_t avs_req,
    output logic [31:0]                avs_readdata,
    output logic                       avs_waitrequest,
    input  wire logic                  serial_rx_pin,
    output logic                       serial_tx_pin
);
    import usc_pkg::*;

    usc_state_t s;
    usc_state_t n;
    logic       tick;
    logic       lp_tick;
    logic       acc;
    logic       lcrh_wr;
    logic       rx_pop;
    logic       tx_push;
    logic       tx_pop;
    logic       rx_push;
    logic       line;
    logic       bitv;
    logic       rx_samp;

    function automatic logic [2:0] last_idx(input logic [1:0] wlen);
        return 3'h4 + {1'b0, wlen};
    endfunction

    function automatic logic par_of(input logic [7:0] d, input logic [7:0] lc);
        logic [7:0] m;
        m = 8'hFF >> (3'h3 - {1'b0, lc[`USC_LC_WLEN_LO+:2]});
        if (lc[`USC_LC_SPS]) begin
            return ~lc[`USC_LC_EPS];
        end
        return (^(d & m)) ^ ~lc[`USC_LC_EPS];
    endfunction

    assign avs_waitrequest = (avs_req.read | avs_req.write) & ~s.ack;
    assign avs_readdata    = {16'h0000, s.rdata};
    assign serial_tx_pin   = s.txd;

    always_comb begin
        logic [7:0]  lc;
        logic [6:0]  fsum;
        logic [7:0]  rdat;
        logic        brk;
        logic        fe;
        n       = s;
        lc      = s.cfg[7:0];
        fsum    = 7'h00;
        rdat    = 8'h00;
        brk     = 1'b0;
        fe      = 1'b0;
        tick    = 1'b0;
        lp_tick = 1'b0;
        tx_pop  = 1'b0;
        rx_push = 1'b0;
        rx_samp = 1'b0;
        bitv    = 1'b1;

        // Bus: first cycle captures read data, second cycle completes
        n.ack   = (avs_req.read | avs_req.write) & ~s.ack;
        acc     = (avs_req.read | avs_req.write) & s.ack;
        lcrh_wr = acc & avs_req.write & (avs_req.address == `USC_OFF_LCRH);
        rx_pop  = acc & avs_req.read & (avs_req.address == `USC_OFF_DATA) & (s.rxc != 5'h00);
        tx_push = acc & avs_req.write & (avs_req.address == `USC_OFF_DATA)
                  & (s.txc != `USC_DEPTH);
        if (avs_req.read & ~s.ack) begin
            if (avs_req.address == `USC_OFF_DATA) begin
                n.rdata = {4'h0, s.rxm[s.rxr]};
            end else if (avs_req.address == `USC_OFF_RSR) begin
                n.rdata = {12'h000, s.rsr};
            end else if (avs_req.address == `USC_OFF_FLAG) begin
                n.rdata = 16'h0000;
                n.rdata[`USC_FL_BUSY] = (s.txc != 5'h00) | (s.tst != ST_IDLE);
                n.rdata[`USC_FL_RXFE] = (s.rxc == 5'h00);
                n.rdata[`USC_FL_TXFF] = (s.txc == `USC_DEPTH);
                n.rdata[`USC_FL_RXFF] = (s.rxc == `USC_DEPTH);
                n.rdata[`USC_FL_TXFE] = (s.txc == 5'h00);
            end else if (avs_req.address == `USC_OFF_ILPR) begin
                n.rdata = {8'h00, s.ilpr};
            end else if (avs_req.address == `USC_OFF_IBRD) begin
                n.rdata = s.ibrd;
            end else if (avs_req.address == `USC_OFF_FBRD) begin
                n.rdata = {10'h000, s.fbrd};
            end else if (avs_req.address == `USC_OFF_LCRH) begin
                n.rdata = {8'h00, s.lcrh};
            end else if (avs_req.address == `USC_OFF_CTL) begin
                n.rdata = {6'h00, s.ctl};
            end else begin
                n.rdata = 16'h0000;
            end
        end
        if (acc & avs_req.write) begin
            if (avs_req.address == `USC_OFF_RSR) begin
                n.rsr = 4'h0;
            end else if (avs_req.address == `USC_OFF_ILPR) begin
                n.ilpr = avs_req.writedata[7:0];
            end else if (avs_req.address == `USC_OFF_IBRD) begin
                n.ibrd = avs_req.writedata[15:0];
            end else if (avs_req.address == `USC_OFF_FBRD) begin
                n.fbrd = avs_req.writedata[5:0];
            end else if (avs_req.address == `USC_OFF_LCRH) begin
                n.lcrh = avs_req.writedata[7:0];
                n.cfg  = {s.ibrd, s.fbrd, avs_req.writedata[7:0]};
            end else if (avs_req.address == `USC_OFF_CTL) begin
                n.ctl = avs_req.writedata[9:0];
            end
        end
        if (rx_pop) begin
            n.rsr = s.rxm[s.rxr][11:8];
        end

        // fractional divider, carry stretches one period
        if (s.cfg[29:14] == 16'h0000) begin
            n.bcnt = 16'h0000;
        end else if (s.bcnt == 16'h0000) begin
            tick   = 1'b1;
            fsum   = {1'b0, s.facc} + {1'b0, s.cfg[13:8]};
            n.facc = fsum[5:0];
            n.bcnt = s.cfg[29:14] - 16'h0001 + {15'h0000, fsum[6]};
        end else begin
            n.bcnt = s.bcnt - 16'h0001;
        end
        // divide by 1..256, zero meaning 256
        if (s.lcnt == 8'h00) begin
            lp_tick = 1'b1;
            n.lcnt  = s.ilpr - 8'h01;
        end else begin
            n.lcnt = s.lcnt - 8'h01;
        end

        // a running frame ignores the enables
        if (s.tst != ST_IDLE) begin
            if (lp_tick & (s.tlp != `USC_LP_PULSE)) begin
                n.tlp = s.tlp + 2'h1;
            end
            if (tick) begin
                n.tsub = s.tsub + 4'h1;
                if (s.tsub == `USC_SUB_LAST) begin
                    n.tlp = 2'h0;
                    n.lcnt = s.ilpr - 8'h01;
                    case (s.tst)
                        ST_START: begin
                            n.tst  = ST_DATA;
                            n.tbit = 3'h0;
                        end
                        ST_DATA: begin
                            n.tsh  = s.tsh >> 1;
                            n.tbit = s.tbit + 3'h1;
                            if (s.tbit == last_idx(lc[`USC_LC_WLEN_LO+:2])) begin
                                n.tst  = lc[`USC_LC_PEN] ? ST_PAR : ST_STOP;
                                n.tbit = 3'h0;
                            end
                        end
                        ST_PAR: begin
                            n.tst = ST_STOP;
                        end
                        ST_STOP: begin
                            if (lc[`USC_LC_STP2] & (s.tbit == 3'h0)) begin
                                n.tbit = 3'h1;
                            end else begin
                                n.tst = ST_IDLE;
                            end
                        end
                        default: begin
                            n.tst = ST_IDLE;
                        end
                    endcase
                end
            end
        end
        // frames start on a tick, straight after the last stop
        // Waiting for a tick keeps the start bit a full sixteen ticks long
        if (tick & (n.tst == ST_IDLE) & (s.txc != 5'h00) & s.ctl[`USC_CT_EN]
            & s.ctl[`USC_CT_TXE]) begin
            tx_pop = 1'b1;
            n.tsh  = s.txm[s.txr];
            n.tpar = par_of(s.txm[s.txr], lc);
            n.tst  = ST_START;
            n.tsub = 4'h0;
            n.tlp  = 2'h0;
            // low-power pulse counts from the bit edge
            n.lcnt = s.ilpr - 8'h01;
        end
        case (s.tst)
            ST_START: bitv = 1'b0;
            ST_DATA:  bitv = s.tsh[0];
            ST_PAR:   bitv = s.tpar;
            default:  bitv = 1'b1;
        endcase
        // break forces a zero bit; outside SIR mode the data line is held low
        if (lc[`USC_LC_BRK]) begin
            bitv = 1'b0;
        end
        if (!s.ctl[`USC_CT_SIR]) begin
            n.txd = bitv;
        end else if (s.ctl[`USC_CT_SIRLP]) begin
            n.txd = ~bitv & (s.tlp != `USC_LP_PULSE);
        end else begin
            n.txd = ~bitv & (s.tsub < `USC_IR_PULSE);
        end

        // Three-stage sync; a change counts once stages two and three agree
        n.sync = {s.sync[1:0], serial_rx_pin};
        if (s.sync[1] == s.sync[2]) begin
            n.rline = s.sync[2];
        end
        // a low pulse is stretched into a zero of about one bit
        if (!s.rline) begin
            n.irh = `USC_SUB_LAST;
        end else if (tick & (s.irh != 4'h0)) begin
            n.irh = s.irh - 4'h1;
        end
        line    = s.ctl[`USC_CT_SIR] ? (s.rline & (s.irh == 4'h0)) : s.rline;
        n.rprev = line;

        case (s.rst)
            ST_IDLE: begin
                // start only on a fall from idle-high
                if (s.ctl[`USC_CT_EN] & s.ctl[`USC_CT_RXE] & !line & s.rprev) begin
                    n.rst  = ST_START;
                    n.rsub = 4'h0;
                end
            end
            ST_START: begin
                if (tick) begin
                    n.rsub = s.rsub + 4'h1;
                    if (s.rsub == `USC_START_MID) begin
                        n.rst  = line ? ST_IDLE : ST_DATA;
                        n.rsub = 4'h0;
                        n.rbit = 3'h0;
                        n.rpe  = 1'b0;
                        n.rpb  = 1'b0;
                    end
                end
            end
            default: begin
                if (tick) begin
                    n.rsub  = s.rsub + 4'h1;
                    rx_samp = (s.rsub == `USC_SUB_LAST);
                end
            end
        endcase
        rdat = s.rsh >> (3'h3 - {1'b0, lc[`USC_LC_WLEN_LO+:2]});
        if (rx_samp) begin
            case (s.rst)
                ST_DATA: begin
                    n.rsh  = {line, s.rsh[7:1]};
                    n.rbit = s.rbit + 3'h1;
                    if (s.rbit == last_idx(lc[`USC_LC_WLEN_LO+:2])) begin
                        n.rst = lc[`USC_LC_PEN] ? ST_PAR : ST_STOP;
                    end
                end
                ST_PAR: begin
                    n.rpe = (line != par_of(rdat, lc));
                    n.rpb = line;
                    n.rst = ST_STOP;
                end
                ST_STOP: begin
                    // low stop is framing, whole frame low is break
                    fe      = !line;
                    brk     = fe & (rdat == 8'h00) & !s.rpb;
                    rx_push = 1'b1;
                    n.rst   = ST_IDLE;
                    // Forces a fresh idle-high before the next start
                    n.rprev = 1'b0;
                end
                default: begin
                    n.rst = ST_IDLE;
                end
            endcase
        end
        // overrun rides with the next stored character
        if (rx_push) begin
            if ((s.rxc == `USC_DEPTH) & !rx_pop) begin
                n.oepend = 1'b1;
                n.rsr[3] = 1'b1;
            end else begin
                n.rxm[s.rxr + s.rxc[3:0]] = {s.oepend, brk, s.rpe, fe, rdat};
                n.oepend = 1'b0;
            end
        end
        if (tx_push) begin
            n.txm[s.txr + s.txc[3:0]] = avs_req.writedata[7:0];
        end
        if (tx_pop) begin
            n.txr = s.txr + 4'h1;
        end
        if (rx_pop) begin
            n.rxr = s.rxr + 4'h1;
        end
        n.txc = s.txc + {4'h0, tx_push} - {4'h0, tx_pop};
        n.rxc = s.rxc + {4'h0, rx_push & ((s.rxc != `USC_DEPTH) | rx_pop)}
                - {4'h0, rx_pop};
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            s       <= '0;
            s.ctl   <= `USC_CTL_RST;
            s.txd   <= 1'b1;
            s.sync  <= 3'h7;
            s.rline <= 1'b1;
            s.rprev <= 1'b1;
        end else begin
            s <= n;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    logic busy_flag;
    assign busy_flag = (s.txc != 5'h00) | (s.tst != ST_IDLE);

    a_busy_held: assert property ((avs_req.read && !s.ack && s.txc != 5'h00
        && avs_req.address == `USC_OFF_FLAG) |=> s.rdata[`USC_FL_BUSY])
        else $error("busy flag low with data queued");
    a_busy_drop: assert property ($fell(busy_flag) |-> $past(s.tst) == ST_STOP)
        else $error("busy dropped before stop bits");
    a_tx_start_low: assert property ((s.tst == ST_START && !s.ctl[`USC_CT_SIR])
        |=> !s.txd)
        else $error("start bit not low");
    a_tx_stop_high: assert property ((s.tst == ST_STOP && !s.ctl[`USC_CT_SIR]
        && !s.cfg[`USC_LC_BRK]) |=> s.txd)
        else $error("stop bit not high");
    a_false_start: assert property ((s.rst == ST_START && tick
        && s.rsub == `USC_START_MID && line) |=> s.rst == ST_IDLE)
        else $error("false start accepted");
    a_rx_store: assert property ((rx_samp && s.rst == ST_STOP && s.rxc != `USC_DEPTH
        && !rx_pop) |=> s.rxc == $past(s.rxc) + 5'h01)
        else $error("received character not stored");
    a_cfg_latch: assert property (!$stable(s.cfg) |-> $past(lcrh_wr))
        else $error("line settings changed without line write");
    a_ir_pulse: assert property ((s.ctl[`USC_CT_SIR] && !s.ctl[`USC_CT_SIRLP]
        && s.tst == ST_START && s.tsub >= `USC_IR_PULSE) |=> !s.txd)
        else $error("IR pulse longer than 3/16");
    a_tx_finish: assert property ((s.tst == ST_DATA && !s.ctl[`USC_CT_EN])
        |=> s.tst != ST_IDLE)
        else $error("frame cut by disable");
    a_en_reset: assert property (!$past(rstn)
        |-> s.ctl[`USC_CT_TXE] && s.ctl[`USC_CT_RXE])
        else $error("enables not set after reset");
endmodule

// ===== tb/uart_with_sir_codec_test.sv
// Self-checking bench for the serial block: bus tasks, scenarios, verdict.
// Assumes usc_top on a 200 MHz mclk and the usc_remote line model.
`include "usc_cfg.svh"
module uart_with_sir_codec_test;
    timeunit 1ns;
    timeprecision 1ps;
    import usc_pkg::*;
    logic         mclk;
    logic         rstn;
    usc_avs_req_t req;
    logic [31:0]  rdata;
    logic         wait_rq;
    logic         rx_line;
    logic         tx_line;
    int           num_errors;
    int           n_compared;
    logic [31:0]  q;

    usc_top u_usc_top (.mclk(mclk), .rstn(rstn), .avs_req(req), .avs_readdata(rdata),
        .avs_waitrequest(wait_rq), .serial_rx_pin(rx_line), .serial_tx_pin(tx_line));
    usc_remote #(.BIT_CYC(32)) u_usc_remote (.mclk(mclk), .tx_line(tx_line),
        .rx_line(rx_line));

    always #2.5 mclk = ~mclk;

    task automatic tally_and_finish();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic fail_wait(input string what);
        num_errors++;
        $display("wrong value %s: expected done, seen timeout", what);
        tally_and_finish();
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Holds the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk);
        req.address   <= a;
        req.read      <= ~w;
        req.write     <= w;
        req.writedata <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (wait_rq === 1'b0) break;
        end
        if (i == 20) fail_wait("waitrequest");
        q = rdata;
        req.read  <= 1'b0;
        req.write <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic wait_flag(input int idx, input logic v);
        for (int i = 0; i < 500; i++) begin
            rd(`USC_OFF_FLAG);
            if (q[idx] === v) return;
        end
        fail_wait("flag");
    endtask

    task automatic wait_got(input int n);
        for (int i = 0; i < 4000; i++) begin
            if (u_usc_remote.got.size() >= n) return;
            @(posedge mclk);
        end
        fail_wait("remote frames");
    endtask

    task automatic rd_data(input logic [31:0] exp);
        wait_flag(`USC_FL_RXFE, 1'b0);
        rd(`USC_OFF_DATA);
        chk("rx data", exp, q);
    endtask

    task automatic pulse(input int exp);
        int n;
        n = 0;
        for (int i = 0; i < 2000 && tx_line !== 1'b1; i++) @(negedge mclk);
        while (tx_line === 1'b1 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        chk("ir pulse", 32'(exp), 32'(n));
    endtask

    task automatic t_reset();
        chk("tx idle", 32'h1, {31'h0, tx_line});
        rd(`USC_OFF_CTL);
        chk("control", 32'h300, q);
        rd(`USC_OFF_FLAG);
        chk("flags", 32'h90, q);
        rd(12'h100);
        chk("unmapped", 32'h0, q);
    endtask

    task automatic t_tx();
        wr(`USC_OFF_IBRD, 32'h2);
        wr(`USC_OFF_FBRD, 32'h0);
        wr(`USC_OFF_LCRH, 32'h60);
        // Divisor change without a line write must stay dormant
        wr(`USC_OFF_IBRD, 32'h5);
        wr(`USC_OFF_CTL, 32'h301);
        wr(`USC_OFF_DATA, 32'hA5);
        wr(`USC_OFF_DATA, 32'h3C);
        rd(`USC_OFF_FLAG);
        chk("busy", 32'h1, {31'h0, q[`USC_FL_BUSY]});
        wait_got(1);
        repeat (48) @(posedge mclk);
        wr(`USC_OFF_CTL, 32'h300);
        wait_got(2);
        chk("frame 0", 32'h2A5, 32'(u_usc_remote.got[0]));
        chk("frame 1", 32'h23C, 32'(u_usc_remote.got[1]));
        wait_flag(`USC_FL_BUSY, 1'b0);
        wr(`USC_OFF_IBRD, 32'h2);
    endtask

    task automatic t_fmt();
        logic [7:0] lc[3] = '{8'h4E, 8'h02, 8'hA6};
        int         nb[3] = '{7, 5, 6};
        logic [7:0] dm;
        logic       pb;
        u_usc_remote.par_en = 1'b1;
        for (int k = 0; k < 3; k++) begin
            // Line settings apply live, so the last frame must be out first
            wait_flag(`USC_FL_BUSY, 1'b0);
            wr(`USC_OFF_CTL, 32'h300);
            wr(`USC_OFF_LCRH, {24'h0, lc[k]});
            wr(`USC_OFF_CTL, 32'h301);
            u_usc_remote.nbits = nb[k];
            u_usc_remote.got.delete();
            wr(`USC_OFF_DATA, 32'h5B);
            wait_got(1);
            dm = 8'h5B & ~(8'hFF << nb[k]);
            pb = lc[k][`USC_LC_SPS] ? ~lc[k][`USC_LC_EPS] : (^dm ^ ~lc[k][`USC_LC_EPS]);
            chk("format", {22'h0, 1'b1, pb, dm}, 32'(u_usc_remote.got[0]));
        end
    endtask

    task automatic t_rx();
        wr(`USC_OFF_CTL, 32'h300);
        wr(`USC_OFF_LCRH, 32'h66);
        wr(`USC_OFF_CTL, 32'h301);
        u_usc_remote.nbits = 8;
        u_usc_remote.send(8'h5A, 1'b0, 1'b1);
        u_usc_remote.send(8'h5A, 1'b1, 1'b1);
        u_usc_remote.send(8'h33, 1'b0, 1'b0);
        rd_data(32'h05A);
        rd_data(32'h25A);
        rd_data(32'h133);
        // Low for only four ticks: a false start
        u_usc_remote.hold(1'b0, 8);
        u_usc_remote.hold(1'b1, 64);
        rd(`USC_OFF_FLAG);
        chk("false start", 32'h1, {31'h0, q[`USC_FL_RXFE]});
        for (int i = 0; i < 17; i++) u_usc_remote.send(8'(i), ^8'(i), 1'b1);
        rd(`USC_OFF_FLAG);
        chk("rx full", 32'h1, {31'h0, q[`USC_FL_RXFF]});
        rd(`USC_OFF_RSR);
        chk("overrun", 32'h8, q & 32'h8);
        for (int i = 0; i < 16; i++) begin
            rd(`USC_OFF_DATA);
            chk("fifo data", 32'(i), q);
        end
        // Twelve bit times low outlasts a whole frame
        u_usc_remote.hold(1'b0, 384);
        u_usc_remote.hold(1'b1, 64);
        rd_data(32'hD00);
        rd(`USC_OFF_RSR);
        chk("break status", 32'h5, q & 32'h7);
    endtask

    task automatic t_ir();
        logic [9:0] fr;
        fr = {1'b1, 8'h5A, 1'b0};
        u_usc_remote.decode_on = 1'b0;
        wr(`USC_OFF_CTL, 32'h300);
        wr(`USC_OFF_LCRH, 32'h61);
        repeat (2) @(posedge mclk);
        chk("break out", 32'h0, {31'h0, tx_line});
        wr(`USC_OFF_LCRH, 32'h60);
        wr(`USC_OFF_ILPR, 32'h4);
        wr(`USC_OFF_CTL, 32'h303);
        repeat (2) @(posedge mclk);
        chk("ir idle", 32'h0, {31'h0, tx_line});
        wr(`USC_OFF_DATA, 32'hFF);
        pulse(6);
        wait_flag(`USC_FL_BUSY, 1'b0);
        wr(`USC_OFF_CTL, 32'h300);
        wr(`USC_OFF_CTL, 32'h307);
        wr(`USC_OFF_DATA, 32'hFF);
        pulse(12);
        // Half-duplex: transmit ends first; the 10 ms settling gap is not modelled
        wait_flag(`USC_FL_BUSY, 1'b0);
        for (int i = 0; i < 10; i++) begin
            // A zero is a short low pulse, a one leaves the line idle
            u_usc_remote.hold(fr[i], 6);
            u_usc_remote.hold(1'b1, 26);
        end
        rd_data(32'h05A);
    endtask

    initial begin
        mclk       = 1'b0;
        rstn       = 1'b0;
        req        = '0;
        num_errors = 0;
        n_compared = 0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        t_reset();
        t_tx();
        t_fmt();
        t_rx();
        t_ir();
        tally_and_finish();
    end
endmodule

// ===== tb/usc_remote.sv
// Remote serial device: decodes frames sent by the block, sends frames to it.
// Assumes bit timing of BIT_CYC mclk cycles; rx_line is driven high while idle.
module usc_remote #(
    parameter int BIT_CYC = 32
) (
    input  wire logic mclk,
    input  wire logic tx_line,
    output logic      rx_line
);
    timeunit 1ns;
    timeprecision 1ps;
    int         nbits     = 8;
    logic       par_en    = 1'b0;
    logic       decode_on = 1'b1;
    logic [9:0] got[$];
    logic [7:0] d;
    logic       p;

    initial rx_line = 1'b1;

    initial begin
        forever begin
            @(negedge mclk);
            if (decode_on && tx_line === 1'b0) begin
                d = 8'h00;
                p = 1'b0;
                repeat (BIT_CYC / 2 - 1) @(negedge mclk);
                for (int i = 0; i < nbits; i++) begin
                    repeat (BIT_CYC) @(negedge mclk);
                    d[i] = tx_line;
                end
                if (par_en) begin
                    repeat (BIT_CYC) @(negedge mclk);
                    p = tx_line;
                end
                repeat (BIT_CYC) @(negedge mclk);
                got.push_back({tx_line, p, d});
            end
        end
    end

    // Caller stands just after a rising edge
    task automatic hold(input logic v, input int cyc);
        rx_line <= v;
        repeat (cyc) @(posedge mclk);
    endtask

    task automatic send(input logic [7:0] v, input logic pb, input logic sb);
        hold(1'b0, BIT_CYC);
        for (int i = 0; i < nbits; i++) hold(v[i], BIT_CYC);
        if (par_en) hold(pb, BIT_CYC);
        hold(sb, BIT_CYC);
        hold(1'b1, BIT_CYC);
    endtask
endmodule
